// *** hw/ahi_pkg.sv ***
// Constants, types and shared definitions of the ADC serial host interface.
// Summary of operation
// R1 - Link runs only in clock polarity zero, clock phase one.
// R2 - Select high resets the serial logic, ignores the clock, floats serial_out.
// R3 - Host keeps select low for a whole command or readback.
// R4 - Host clocks continuously or in bytes and keeps the clock low when idle.
// R5 - Ready falls on a new result and rises on the next clock falling edge.
// R6 - Unread result: ready pulses high two master clocks before the next fall.
// R7 - Ready pin is always driven, even with select high.
// R8 - Host ends a readback four master clocks before the next ready fall.
// R9 - serial_in is sampled on clock falling edges and never driven.
// R10 - serial_out changes on rising edges; host samples on falling edges.
// R11 - chain_in is captured on each clock falling edge.
// R12 - Optional timeout resets the serial logic after 2^14 or 2^16 master clocks.
// R13 - Opcode 0000 011x resets the device; system opcodes decode on falling edge seven.
// R14 - Opcode 0000 100x restarts filters; ready stays quiet meanwhile.
// R15 - Opcode 0000 101x stops conversions.
// R16 - Host holds the start pin low when using start and stop opcodes.
// R17 - Opcode 0001 0010 reloads the result; its top bit leaves on clock nine.
// R18 - Read command returns count plus one register bytes from the given address.
// R19 - Write command stores count plus one bytes at consecutive addresses.
// R20 - Frame master makes frame and bit clocks, 32 bits per frame, data on falls.
// R21 - Frame master starts each word, top bit first, at frame rising edge.
// R22 - In frame mode commands are unavailable; host ties serial_in and select low.
// R23 - Interface select low chooses the serial mode with the ready output.
// R24 - Frame mode with role pin high makes the device drive both clocks.
package ahi_pkg;

   localparam int unsigned DATA_W         = 24;
   localparam int unsigned FRAME_BITS     = 32;
   localparam int unsigned FRAME_HI_BITS  = 16;
   localparam int unsigned PULSE_CYC      = 2;
   localparam int unsigned FS_HALF_CYC    = 2;
   localparam int unsigned FILT_HOLD_CYC  = 8;
   localparam int unsigned TOUT_SHORT_DEF = 16384;
   localparam int unsigned TOUT_LONG_DEF  = 65536;

   localparam logic [6:0] OP_RESET7 = 7'h03;
   localparam logic [6:0] OP_START7 = 7'h04;
   localparam logic [6:0] OP_STOP7  = 7'h05;
   localparam logic [7:0] OP_RDATA  = 8'h12;
   localparam logic [3:0] NIB_READ_REGS_CMD  = 4'h2;
   localparam logic [3:0] NIB_WRITE_REGS_CMD  = 4'h4;
   localparam logic [7:0] CFG_RST   = 8'h00;
   localparam logic [4:0] FS_BIT_RST = 5'h1f;

   typedef enum logic [1:0] {ST_OP, ST_CNT, ST_WR, ST_RD} ahi_state_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
   } ahi_wr_s;

   typedef struct packed {
      logic run;
      logic dev_reset;
      logic filt_reset;
   } ahi_ctl_s;

endpackage

// *** hw/ahi_sync.sv ***
// Two flip-flop synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
module ahi_sync
#(
   parameter int unsigned W = 1
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta <= '0;
         q_o  <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// *** hw/ahi_serial_host_if.sv ***
// Serial host interface of the converter: serial target, ready logic and frame master.
`timescale 1ns/1ps
module ahi_serial_host_if
   import ahi_pkg::*;
#(
   parameter int unsigned TOUT_SHORT_CYC = TOUT_SHORT_DEF,
   parameter int unsigned TOUT_LONG_CYC  = TOUT_LONG_DEF
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_b_i,
   input  wire logic        din_i,
   input  wire logic        chain_in_i,
   input  wire logic        interface_sel_i,
   input  wire logic        frame_role_pin_i,
   input  wire logic        timeout_en_i,
   input  wire logic        timeout_length_sel_i,
   input  wire logic [23:0] result_i,
   input  wire logic        result_valid_i,
   output logic             sclk_o,
   output logic             sclk_oe_o,
   output logic             dout_o,
   output logic             dout_oe_o,
   output logic             ready_or_frame_pin_o,
   output logic             ready_or_frame_pin_oe_o,
   output ahi_ctl_s         ctl_o,
   output logic             cfg_wr_o,
   output ahi_wr_s          cfg_o
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]  shin;
   logic [2:0]  fcnt;
   ahi_state_e  st;
   logic        is_rd;
   logic [3:0]  ptr;
   logic [3:0]  left;
   logic [7:0]  rd_byte;
   logic [7:0]  regs [16];
   logic        chain_q;
   logic        busy_q;
   logic        rdata_tg;
   logic        rdata_seen;
   logic [4:0]  idx;
   logic        dout_spi;
   logic        fall_tg;
   logic        reset_tg;
   logic        start_tg;
   logic        stop_tg;
   logic        wr_tg;
   ahi_wr_s     wr_hold;
   logic [8:0]  sy;
   logic [4:0]  sy_p;
   logic        tout_rst;
   logic        spi_dis;
   logic [16:0] tout_cnt;
   logic        ready_b;
   logic        pulsing;
   logic        pulse_cnt;
   logic [3:0]  filt_cnt;
   logic [23:0] data_word;
   logic [1:0]  fs_div;
   logic        fs_sclk;
   logic [4:0]  fs_bitno;
   logic        fs_frame;
   logic        fs_dout;
   logic [23:0] fs_word;
   logic        fs_on;

   // ****************************************************************
   // Serial target, falling edge side
   // ****************************************************************
   // Select high, a timeout or frame mode holds the serial logic in reset.
   // R2 select resets logic
   wire spi_rst_b = rst_b_i & ~cs_b_i & ~tout_rst & ~spi_dis;

   wire [7:0] byte_in   = {shin[6:0], din_i};
   wire       byte_end  = fcnt == 3'd7;
   wire       op7_hit   = (st == ST_OP) && (fcnt == 3'd6);
   wire       dec_reset = op7_hit && (byte_in[6:0] == OP_RESET7);
   wire       dec_start = op7_hit && (byte_in[6:0] == OP_START7);
   wire       dec_stop  = op7_hit && (byte_in[6:0] == OP_STOP7);
   wire       dec_rdata = (st == ST_OP) && byte_end && (byte_in == OP_RDATA);
   wire       dec_reg   = (st == ST_OP) && byte_end
                          && ((byte_in[7:4] == NIB_READ_REGS_CMD) || (byte_in[7:4] == NIB_WRITE_REGS_CMD));
   wire       wr_byte   = (st == ST_WR) && byte_end;
   wire       rd_byte_e = (st == ST_RD) && byte_end;
   wire [2:0] next_fcnt = fcnt + 3'd1;

   ahi_state_e next_st;
   always_comb
   begin
      next_st = st;
      case (st)
         ST_OP:   next_st = dec_reg ? ST_CNT : ST_OP;
         ST_CNT:  next_st = byte_end ? (is_rd ? ST_RD : ST_WR) : ST_CNT;
         ST_WR,
         ST_RD:   next_st = (byte_end && (left == 4'h0)) ? ST_OP : st;
         default: next_st = ST_OP;
      endcase
   end

   // R9 falling edge sampling
   always_ff @(negedge sclk_i or negedge spi_rst_b)
   begin
      if (!spi_rst_b)
      begin
         shin     <= 8'h00;
         fcnt     <= 3'd0;
         st       <= ST_OP;
         is_rd    <= 1'b0;
         ptr      <= 4'h0;
         left     <= 4'h0;
         rd_byte  <= 8'h00;
         chain_q  <= 1'b0;
         busy_q   <= 1'b0;
         rdata_tg <= 1'b0;
      end
      else
      begin
         shin    <= byte_in;
         fcnt    <= next_fcnt;
         st      <= next_st;
         // R11 chain capture
         chain_q <= chain_in_i;
         busy_q  <= (next_st != ST_OP) || (next_fcnt != 3'd0);
         // R17 data reload
         rdata_tg <= rdata_tg ^ dec_rdata;
         if (dec_reg)
         begin
            is_rd <= byte_in[7:4] == NIB_READ_REGS_CMD;
            ptr   <= byte_in[3:0];
         end
         // R18 R19 byte count
         if ((st == ST_CNT) && byte_end)
         begin
            left    <= byte_in[3:0];
            rd_byte <= regs[ptr];
         end
         if (wr_byte || rd_byte_e)
         begin
            ptr     <= ptr + 4'h1;
            left    <= left - 4'h1;
            rd_byte <= regs[ptr + 4'h1];
         end
      end
   end

   // Event toggles survive select, so the master clock side never sees a false edge.
   always_ff @(negedge sclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fall_tg  <= 1'b0;
         reset_tg <= 1'b0;
         start_tg <= 1'b0;
         stop_tg  <= 1'b0;
         wr_tg    <= 1'b0;
         wr_hold  <= '0;
      end
      else if (spi_rst_b)
      begin
         fall_tg  <= ~fall_tg;
         // R13 R14 R15 decode on seventh edge
         reset_tg <= reset_tg ^ dec_reset;
         start_tg <= start_tg ^ dec_start;
         stop_tg  <= stop_tg ^ dec_stop;
         wr_tg    <= wr_tg ^ wr_byte;
         if (wr_byte)
         begin
            wr_hold <= '{addr: ptr, data: byte_in};
         end
      end
   end

   // R19 register store
   always_ff @(negedge sclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < 16; i++)
         begin
            regs[i] <= CFG_RST;
         end
      end
      else if (spi_rst_b && dec_reset)
      begin
         for (int i = 0; i < 16; i++)
         begin
            regs[i] <= CFG_RST;
         end
      end
      else if (spi_rst_b && wr_byte)
      begin
         regs[ptr] <= byte_in;
      end
   end

   // ****************************************************************
   // Serial target, rising edge side
   // ****************************************************************
   // The result word is read across domains without a handshake; it is held
   // still by the keep-out window that the host observes before each new result.
   wire       restart  = rdata_tg != rdata_seen;
   wire [4:0] didx     = 5'(DATA_W - 1) - idx;
   wire       data_bit = (idx < 5'(DATA_W)) ? data_word[didx] : chain_q;
   wire       next_out = (st == ST_RD) ? rd_byte[~fcnt]
                       : restart ? data_word[DATA_W-1] : data_bit;

   // R1 R10 rising edge update
   always_ff @(posedge sclk_i or negedge spi_rst_b)
   begin
      if (!spi_rst_b)
      begin
         idx        <= 5'd0;
         dout_spi   <= 1'b0;
         rdata_seen <= 1'b0;
      end
      else
      begin
         dout_spi   <= next_out;
         rdata_seen <= rdata_tg;
         idx        <= restart ? 5'd1 : (idx == 5'(DATA_W)) ? idx : idx + 5'd1;
      end
   end

   // ****************************************************************
   // Crossings into the master clock domain
   // ****************************************************************
   // Select travels inverted, so the reset value of the synchroniser reads as deselected
   // and the output enable cannot flicker on just after reset.
   ahi_sync #(.W(9)) u_sync
   (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     ({~cs_b_i, interface_sel_i, frame_role_pin_i, busy_q,
                 fall_tg, reset_tg, start_tg, stop_tg, wr_tg}),
      .q_o     (sy)
   );

   wire cs_s      = ~sy[8];
   wire spi_mode  = ~sy[7];
   wire fs_master = sy[7] & sy[6];
   wire busy_s    = sy[5];
   wire fall_evt  = sy[4] ^ sy_p[4];
   wire reset_evt = sy[3] ^ sy_p[3];
   wire start_evt = sy[2] ^ sy_p[2];
   wire stop_evt  = sy[1] ^ sy_p[1];
   wire wr_evt    = sy[0] ^ sy_p[0];

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sy_p    <= 5'h00;
         spi_dis <= 1'b0;
         cfg_wr_o <= 1'b0;
         cfg_o   <= '0;
      end
      else
      begin
         sy_p     <= sy[4:0];
         // R23 serial mode select
         spi_dis  <= ~spi_mode;
         cfg_wr_o <= wr_evt;
         if (wr_evt)
         begin
            cfg_o <= wr_hold;
         end
      end
   end

   // ****************************************************************
   // Timeout and converter control
   // ****************************************************************
   wire [16:0] tout_lim = timeout_length_sel_i ? 17'(TOUT_LONG_CYC - 1)
                                               : 17'(TOUT_SHORT_CYC - 1);
   wire        tout_hit = timeout_en_i && busy_s && (tout_cnt == tout_lim);

   // R12 timeout on master clocks spent inside a command, not reset by clock activity
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tout_cnt <= 17'h00000;
         tout_rst <= 1'b0;
      end
      else
      begin
         tout_rst <= tout_hit;
         tout_cnt <= (!timeout_en_i || !busy_s || tout_hit) ? 17'h00000 : tout_cnt + 17'h1;
      end
   end

   // R13 R14 R15 converter control
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ctl_o    <= '0;
         filt_cnt <= 4'h0;
      end
      else
      begin
         ctl_o.dev_reset  <= reset_evt;
         ctl_o.filt_reset <= reset_evt | start_evt;
         ctl_o.run        <= start_evt ? 1'b1 : (stop_evt | reset_evt) ? 1'b0 : ctl_o.run;
         filt_cnt <= (reset_evt | start_evt) ? 4'(FILT_HOLD_CYC)
                   : (filt_cnt != 4'h0) ? filt_cnt - 4'h1 : filt_cnt;
      end
   end

   // ****************************************************************
   // Ready indicator
   // ****************************************************************
   wire filt_hold = filt_cnt != 4'h0;

   // R5 R6 R14 ready sequencing
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ready_b   <= 1'b1;
         pulsing   <= 1'b0;
         pulse_cnt <= 1'b0;
         data_word <= 24'h000000;
      end
      else if (filt_hold)
      begin
         ready_b <= 1'b1;
         pulsing <= 1'b0;
      end
      else if (pulsing)
      begin
         pulse_cnt <= 1'b0;
         pulsing   <= pulse_cnt;
         ready_b   <= pulse_cnt;
      end
      else if (result_valid_i)
      begin
         data_word <= result_i;
         pulsing   <= ~ready_b;
         pulse_cnt <= 1'(PULSE_CYC - 1);
         ready_b   <= ~ready_b;
      end
      else if (fall_evt)
      begin
         ready_b <= 1'b1;
      end
   end

   // ****************************************************************
   // Frame-sync master
   // ****************************************************************
   wire       fs_tick = fs_div == 2'(FS_HALF_CYC - 1);
   wire       fs_fall = fs_tick && fs_sclk;
   wire [4:0] fs_next = fs_bitno + 5'd1;
   wire [4:0] fs_idx  = 5'(DATA_W - 1) - fs_next;

   // R20 R21 R24 frame master
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fs_div   <= 2'd0;
         fs_sclk  <= 1'b0;
         fs_bitno <= FS_BIT_RST;
         fs_frame <= 1'b0;
         fs_dout  <= 1'b0;
         fs_word  <= 24'h000000;
      end
      else if (!fs_master)
      begin
         fs_div   <= 2'd0;
         fs_sclk  <= 1'b0;
         fs_bitno <= FS_BIT_RST;
         fs_frame <= 1'b0;
         fs_dout  <= 1'b0;
      end
      else
      begin
         fs_div <= fs_tick ? 2'd0 : fs_div + 2'd1;
         if (fs_tick)
         begin
            fs_sclk <= ~fs_sclk;
         end
         if (fs_fall)
         begin
            fs_bitno <= fs_next;
            fs_frame <= fs_next < 5'(FRAME_HI_BITS);
            if (fs_next == 5'd0)
            begin
               fs_word <= data_word;
               fs_dout <= data_word[DATA_W-1];
            end
            else
            begin
               fs_dout <= (fs_next < 5'(DATA_W)) ? fs_word[fs_idx] : 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   // R7 ready always driven
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fs_on                   <= 1'b0;
         sclk_oe_o               <= 1'b0;
         dout_oe_o               <= 1'b0;
         ready_or_frame_pin_oe_o <= 1'b1;
      end
      else
      begin
         fs_on                   <= fs_master;
         sclk_oe_o               <= fs_master;
         dout_oe_o               <= fs_master | (spi_mode & ~cs_s);
         ready_or_frame_pin_oe_o <= spi_mode | fs_master;
      end
   end

   // The data pin mux chooses between flops of two domains; mode changes are static.
   assign sclk_o               = fs_sclk;
   assign dout_o               = fs_on ? fs_dout : dout_spi;
   assign ready_or_frame_pin_o = fs_on ? fs_frame : ready_b;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_two_high;
      ready_b [*2] ##1 !ready_b;
   endsequence

   sequence s_unread_result;
      result_valid_i && !ready_b && !pulsing && !filt_hold;
   endsequence

   a_ready_pulse_two: assert property (s_unread_result |=> s_two_high) // R6
      else $error("ready pulse is not two cycles");
   a_ready_new_low: assert property (result_valid_i && ready_b && !pulsing && !filt_hold
                                     |=> !ready_b) // R5
      else $error("ready did not fall on new result");
   a_ready_rise_edge: assert property (fall_evt && !result_valid_i && !pulsing && !filt_hold
                                       |=> ready_b) // R5
      else $error("ready did not rise after clock falling edge");
   a_ready_oe_on: assert property (spi_mode [*2] |-> ready_or_frame_pin_oe_o) // R7
      else $error("ready pin not driven");
   a_filt_quiet: assert property ($rose(filt_hold) |=> ready_b [*3]) // R14
      else $error("ready toggled during filter reset");
   a_stop_halts: assert property (stop_evt && !start_evt |=> !ctl_o.run) // R15
      else $error("stop did not halt conversions");
   a_reset_cmd: assert property (reset_evt |=> ctl_o.dev_reset && !ctl_o.run
                                 ##1 !ctl_o.dev_reset) // R13
      else $error("reset command pulse wrong");
   a_tout_fire: assert property (tout_hit |=> tout_rst ##1 !tout_rst) // R12
      else $error("timeout did not reset serial logic");
   a_tout_off: assert property (!timeout_en_i |=> !tout_rst) // R12
      else $error("timeout fired while disabled");
   a_fs_frame_start: assert property ($rose(fs_frame) |-> fs_bitno == 5'd0
                                      && fs_dout == fs_word[DATA_W-1]) // R21
      else $error("frame did not start with word top bit");
   a_fs_bits: assert property (fs_fall && fs_bitno == 5'(FRAME_BITS - 1)
                               |=> fs_bitno == 5'd0 && fs_frame) // R20
      else $error("frame is not 32 bit clocks");
endmodule

// *** testbench/ahi_host_model.sv ***
// Host side model: serial master of the converter's mode one link.
`timescale 1ns/1ps
module ahi_host_model
(
   input  wire logic dout_i,
   input  wire logic dout_oe_i,
   output logic      sclk_o,
   output logic      cs_b_o,
   output logic      din_o
);
   logic last;
   initial
   begin
      sclk_o = 1'b0;
      cs_b_o = 1'b1;
      din_o  = 1'b0;
      last   = 1'b0;
   end
   // mode one
   // The clock idles low and runs only inside transfers; data is taken at the fall.
   // A released line shows the inverse of its last level, so a float never reads clean.
   task automatic bit_x(input logic tx, output logic rx);
      sclk_o = 1'b1;
      din_o  = tx;
      #7.5;
      rx     = dout_oe_i ? dout_i : ~last;
      last   = rx;
      sclk_o = 1'b0;
      #7.5;
   endtask
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(tx[i], rx[i]);
      end
   endtask
   task automatic nibble(input logic [3:0] tx);
      logic d;
      for (int i = 3; i >= 0; i--)
      begin
         bit_x(tx[i], d);
      end
   endtask
   // select framing
   // The odd delay keeps the link out of step with the master clock.
   task automatic sel(input logic b);
      #3.3 cs_b_o = b;
      #20;
   endtask
endmodule

// *** testbench/adc_serial_host_interface_tb.sv ***
// Self-checking bench of the serial host interface.
`timescale 1ns/1ps
module adc_serial_host_interface_tb;
   import ahi_pkg::*;
   logic clk, rst_b, sclk_h, cs_b, din, chain_in, if_sel, role, tout_en, tout_sel, rvalid;
   logic [23:0] result;
   logic        sclk_d, sclk_oe, dout, dout_oe, rdy, rdy_oe, cfg_wr;
   wire logic   sclk_w = sclk_oe ? sclk_d : sclk_h;
   ahi_ctl_s    ctl;
   ahi_wr_s     cfg, wr_last;
   int          failures, check_count, wr_n, fr_n, dr_n;
   logic [7:0]  b0, b1, b2, b3;
   logic [31:0] fw;
   ahi_serial_host_if #(.TOUT_SHORT_CYC(64), .TOUT_LONG_CYC(256)) u_dut
   (
      .clk_i                   (clk),
      .rst_b_i                 (rst_b),
      .sclk_i                  (sclk_w),
      .cs_b_i                  (cs_b),
      .din_i                   (din),
      .chain_in_i              (chain_in),
      .interface_sel_i         (if_sel),
      .frame_role_pin_i        (role),
      .timeout_en_i            (tout_en),
      .timeout_length_sel_i    (tout_sel),
      .result_i                (result),
      .result_valid_i          (rvalid),
      .sclk_o                  (sclk_d),
      .sclk_oe_o               (sclk_oe),
      .dout_o                  (dout),
      .dout_oe_o               (dout_oe),
      .ready_or_frame_pin_o    (rdy),
      .ready_or_frame_pin_oe_o (rdy_oe),
      .ctl_o                   (ctl),
      .cfg_wr_o                (cfg_wr),
      .cfg_o                   (cfg)
   );
   ahi_host_model u_host
   (
      .dout_i    (dout),
      .dout_oe_i (dout_oe),
      .sclk_o    (sclk_h),
      .cs_b_o    (cs_b),
      .din_o     (din)
   );
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      if (cfg_wr === 1'b1)
      begin
         wr_n++;
         wr_last = cfg;
      end
      if (ctl.filt_reset === 1'b1) fr_n++;
      if (ctl.dev_reset === 1'b1) dr_n++;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // keep-out
   // Results are only offered while the host is idle.
   task automatic pulse(input logic [23:0] v);
      @(posedge clk);
      rvalid <= 1'b1;
      result <= v;
      @(posedge clk);
      rvalid <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      u_host.shift(tx, rx);
   endtask
   task automatic write_regs_cmd(input logic [3:0] a, input logic [7:0] d);
      xfer({NIB_WRITE_REGS_CMD, a}, b3);
      xfer(8'h00, b3);
      xfer(d, b3);
   endtask
   task automatic read_regs_cmd(input logic [3:0] a, output logic [7:0] d);
      xfer({NIB_READ_REGS_CMD, a}, b3);
      xfer(8'h00, b3);
      xfer(8'h00, d);
   endtask
   // no start pin here; conversions are run by the opcodes alone.
   task automatic sys(input logic [7:0] op);
      u_host.sel(1'b0);
      xfer(op, b3);
      u_host.sel(1'b1);
      tick(8);
   endtask
   initial
   begin
      clk      = 1'b0;
      chain_in = 1'b0;
      if_sel   = 1'b0;
      // serial mode with the role pin low
      role     = 1'b0;
      tout_en  = 1'b0;
      tout_sel = 1'b0;
      rvalid   = 1'b0;
      {failures, check_count, wr_n, fr_n, dr_n} = '0;
      result = '0;
      rst_b  = 1'b0;
      tick(4);
      rst_b <= 1'b1;
      tick(4);
      #1 check(rdy, 1);
      check(rdy_oe, 1);
      check(dout_oe, 0);
      $display("test reset finished");
      pulse(24'ha5c3e1);
      tick(1);
      #1 check(rdy, 0);
      pulse(24'h3c5a96);
      tick(1);
      #1 check(rdy, 1);
      tick(1);
      #1 check(rdy, 0);
      chain_in <= 1'b1;
      u_host.sel(1'b0);
      xfer(OP_RDATA, b3);
      xfer(8'h00, b2);
      xfer(8'h00, b1);
      xfer(8'h00, b0);
      xfer(8'h00, b3);
      check(dout_oe, 1);
      u_host.sel(1'b1);
      tick(6);
      #1 check({b2, b1, b0}, 24'h3c5a96);
      check(b3, 8'hff);
      check(rdy, 1);
      check(dout_oe, 0);
      $display("test readback finished");
      u_host.sel(1'b0);
      xfer(8'h41, b3);
      xfer(8'h01, b3);
      xfer(8'hc3, b3);
      xfer(8'h5a, b3);
      xfer(8'h21, b3);
      xfer(8'h01, b3);
      xfer(8'h00, b1);
      xfer(8'h00, b0);
      u_host.sel(1'b1);
      check(wr_n, 2);
      check(wr_last, {4'h2, 8'h5a});
      check({b1, b0}, 16'hc35a);
      $display("test registers finished");
      u_host.sel(1'b0);
      xfer(8'h09, b3);
      // The result is offered while the filters are still held in reset.
      pulse(24'h123456);
      u_host.sel(1'b1);
      check(fr_n, 1);
      #1 check(rdy, 1);
      check(ctl.run, 1);
      sys(8'h0a);
      check(ctl.run, 0);
      sys(8'h07);
      check(dr_n, 1);
      u_host.sel(1'b0);
      read_regs_cmd(4'h1, b0);
      u_host.sel(1'b1);
      check(b0, CFG_RST);
      $display("test system opcodes finished");
      u_host.sel(1'b0);
      xfer(8'h41, b3);
      xfer(8'h00, b3);
      u_host.nibble(4'hf);
      u_host.sel(1'b1);
      u_host.sel(1'b0);
      write_regs_cmd(4'h0, 8'h11);
      read_regs_cmd(4'h0, b0);
      u_host.sel(1'b1);
      check(b0, 8'h11);
      check(wr_n, 3);
      tout_en <= 1'b1;
      u_host.sel(1'b0);
      u_host.nibble(4'h4);
      tick(100);
      // long limit lets whole commands through that the short one would cut.
      tout_sel <= 1'b1;
      write_regs_cmd(4'h3, 8'h22);
      read_regs_cmd(4'h3, b0);
      u_host.sel(1'b1);
      check(b0, 8'h22);
      $display("test abort and timeout finished");
      if_sel <= 1'b1;
      role   <= 1'b1;
      // select tied low in frame mode
      u_host.sel(1'b0);
      tick(10);
      #1 check(sclk_oe, 1);
      b0 = 0;
      b1 = 0;
      fw = '0;
      for (int i = 0; i < 1200 && b1 < 2; i++)
      begin
         b2 = {sclk_d, rdy};
         tick(1);
         #1;
         if (!b2[0] && rdy) b1++;
         if (b1 == 1 && !b2[1] && sclk_d)
         begin
            b0++;
            fw = {fw[30:0], dout};
         end
      end
      check(b1, 2);
      check(b0, FRAME_BITS);
      check(fw, {24'h3c5a96, 8'h00});
      $display("test frame master finished");
      print_verdict();
   end
endmodule
